// ---- verification/fspc_cpu_model.sv ----
// Far-side model: flash array watching program strobes and the CPU halt
module fspc_cpu_model (
	input wire logic clock,
	input wire logic cpu_stall,
	input wire logic flash_write,
	input wire logic [15:0] flash_wdata,
	output int stall_n,
	output int hits
);
	timeunit 1ns;
	timeprecision 1ps;
	logic was_stall = 1'b0;
	int stall_r = 0;
	int hits_r = 0;
	assign stall_n = stall_r;
	assign hits = hits_r;
	// Halt length of the latest operation, sampled where registered outputs have settled
	always @(negedge clock) begin
		if (cpu_stall === 1'b1)
			stall_r <= (was_stall === 1'b1) ? stall_r + 1 : 1;
		was_stall <= cpu_stall;
		if (flash_write === 1'b1 && flash_wdata === 16'hbeef)
			hits_r <= hits_r + 1;
	end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking testbench of the flash self-program control block
module tb_top;
	import fspc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst_n, reg_wr, reg_rd, reg_io_space, global_irq_flag;
	logic eeprom_write_active, store_req, load_req, load_special, cpu_stall;
	logic program_ready_irq, flash_erase, flash_write, erase_seen;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, load_data, v;
	logic [15:0] z_pointer, pair_data, flash_wdata;
	logic [6:0] page_address_field;
	logic [4:0] flash_word;
	int err_count = 0;
	int total_checks = 0;
	int stall_n, hits;
	logic [7:0] rc [5] = '{8'h89, 8'h89, 8'h89, 8'h89, 8'ha1};
	logic [15:0] rz [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0000};
	logic [7:0] rx [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h3c};
	fspc_top #(.PROG_CYCLES(20), .SIGNATURE_BYTE(8'h3c)) fspc_top_inst (.clock, .rst_n,
		.reg_wr, .reg_rd,
		.reg_io_space, .reg_addr, .reg_wdata, .reg_rdata, .global_irq_flag,
		.eeprom_write_active, .store_req, .load_req, .z_pointer, .pair_data,
		.load_special, .load_data, .cpu_stall, .program_ready_irq, .flash_erase,
		.flash_write, .page_address_field, .flash_wdata, .flash_word,
		.fuse_low(8'h11), .fuse_high(8'h44), .fuse_ext(8'h33), .lock_bits(8'h22));
	fspc_cpu_model fspc_cpu_model_inst (.clock, .cpu_stall, .flash_write, .flash_wdata,
		.stall_n, .hits);
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic report_and_stop;
		if (err_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Register write, then a store or load after gap extra cycles
	task automatic op(input logic [7:0] cmd, input logic [15:0] z, input logic st,
		input logic ld, input int gap);
		@(negedge clock);
		reg_wr = 1'b1;
		reg_wdata = cmd;
		@(negedge clock);
		reg_wr = 1'b0;
		repeat (gap) @(negedge clock);
		store_req = st;
		load_req = ld;
		z_pointer = z;
		#1;
		erase_seen = flash_erase;
		@(negedge clock);
		store_req = 1'b0;
		load_req = 1'b0;
	endtask
	task automatic rd(output logic [7:0] d);
		@(negedge clock);
		reg_rd = 1'b1;
		#1;
		d = reg_rdata;
		@(negedge clock);
		reg_rd = 1'b0;
	endtask
	task automatic wait_idle;
		repeat (40) if (cpu_stall === 1'b1) @(negedge clock);
		chk(cpu_stall, 1'b0);
	endtask
	initial begin
		#5us;
		err_count++;
		report_and_stop();
	end
	initial begin
		{rst_n, reg_wr, reg_rd, reg_io_space, store_req, load_req} = 6'h00;
		{global_irq_flag, eeprom_write_active} = 2'h2;
		reg_addr = 8'h57;
		reg_wdata = 8'h00;
		z_pointer = 16'h0000;
		pair_data = 16'h0000;
		erase_seen = 1'b0;
		repeat (12) @(negedge clock);
		rst_n = 1'b1;
		rd(v);
		chk(v, FSPC_CSR_RESET);
		op(8'hc0, 16'h0000, 1'b0, 1'b0, 0);
		rd(v);
		chk(v, 8'h80);
		chk(program_ready_irq, 1'b1);
		@(negedge clock);
		global_irq_flag = 1'b0;
		#1;
		chk(program_ready_irq, 1'b0);
		@(negedge clock);
		global_irq_flag = 1'b1;
		eeprom_write_active = 1'b1;
		#1;
		chk(program_ready_irq, 1'b0);
		op(8'h83, 16'h0000, 1'b1, 1'b0, 0);
		chk(erase_seen, 1'b0);
		eeprom_write_active = 1'b0;
		for (int i = 0; i < 5; i++) begin
			op(rc[i], rz[i], 1'b0, 1'b1, 0);
			chk(load_special, 1'b1);
			chk(load_data, rx[i]);
		end
		pair_data = 16'hbeef;
		op(8'h81, 16'h0043, 1'b1, 1'b0, 0);
		rd(v);
		chk(v[0], 1'b0);
		op(8'h85, 16'h0040, 1'b1, 1'b0, 0);
		chk(cpu_stall, 1'b1);
		chk(program_ready_irq, 1'b0);
		rd(v);
		chk(v[2:0], 3'h5);
		wait_idle();
		chk(16'(stall_n), 16'd20);
		chk(16'(hits), 16'd1);
		rd(v);
		chk(v, 8'h80);
		chk(program_ready_irq, 1'b1);
		op(8'h81, 16'h0042, 1'b1, 1'b0, 0);
		op(8'h91, 16'h0000, 1'b1, 1'b0, 0);
		op(8'h85, 16'h0040, 1'b1, 1'b0, 0);
		wait_idle();
		chk(16'(hits), 16'd1);
		op(8'h83, 16'h0fc0, 1'b1, 1'b0, 3);
		chk(erase_seen, 1'b1);
		chk(page_address_field, 7'h3f);
		wait_idle();
		rd(v);
		chk(v, 8'h80);
		op(8'h83, 16'h0fc0, 1'b1, 1'b0, 4);
		chk(erase_seen, 1'b0);
		chk(cpu_stall, 1'b0);
		op(8'h87, 16'h0000, 1'b1, 1'b0, 0);
		chk(cpu_stall, 1'b0);
		rd(v);
		chk(v, 8'h80);
		reg_io_space = 1'b1;
		reg_addr = 8'h37;
		op(8'h83, 16'h0000, 1'b1, 1'b0, 0);
		chk(erase_seen, 1'b1);
		wait_idle();
		op(8'ha1, 16'h0042, 1'b1, 1'b0, 0);
		chk(cpu_stall, 1'b0);
		op(8'h85, 16'h0040, 1'b1, 1'b0, 0);
		wait_idle();
		chk(16'(hits), 16'd1);
		op(8'h81, 16'h0042, 1'b1, 1'b0, 0);
		@(negedge clock);
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		rd(v);
		chk(v, FSPC_CSR_RESET);
		op(8'h85, 16'h0040, 1'b1, 1'b0, 0);
		wait_idle();
		chk(16'(hits), 16'd1);
		report_and_stop();
	end
endmodule

// ---- verilog/fspc_buf_if.sv ----
// Interface between the controller and its temporary page buffer
interface fspc_buf_if #(parameter int AW = 5);
	logic wr;
	logic clr;
	logic [AW-1:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport ctl (output wr, output clr, output addr, output wdata, input rdata);
	modport mem (input wr, input clr, input addr, input wdata, output rdata);
endinterface

// ---- verilog/fspc_page_buf.sv ----
// Temporary page buffer with whole-buffer clear and registered read data
module fspc_page_buf #(
	parameter int AW = 5
) (
	input wire logic clock,
	input wire logic rst_n,
	fspc_buf_if.mem bus
);
	logic [15:0] mem_r [2**AW];
	logic [15:0] rdata_r;
	always_ff @(posedge clock) begin
		if (!rst_n || bus.clr) begin
			for (int i = 0; i < 2**AW; i++) begin
				mem_r[i] <= 16'hffff;
			end
		end else if (bus.wr) begin
			mem_r[bus.addr] <= bus.wdata;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_r <= 16'hffff;
		end else begin
			rdata_r <= mem_r[bus.addr];
		end
	end
	assign bus.rdata = rdata_r;
endmodule

// ---- verilog/fspc_pkg.sv ----
// Shared constants and types of the flash self-program control block
package fspc_pkg;
	localparam logic [7:0] FSPC_CSR_DATA_ADDR = 8'h57;
	localparam logic [7:0] FSPC_IO_OFFSET = 8'h20;
	localparam logic [7:0] FSPC_CSR_IO_ADDR = FSPC_CSR_DATA_ADDR - FSPC_IO_OFFSET;
	localparam logic [7:0] FSPC_CSR_RESET = 8'h00;
	localparam int FSPC_BIT_IRQ_EN = 7;
	localparam int FSPC_BIT_RW_BUSY = 6;
	localparam int FSPC_BIT_SIG = 5;
	localparam int FSPC_BIT_SRE = 4;
	localparam int FSPC_BIT_LOCK = 3;
	localparam int FSPC_BIT_PGWR = 2;
	localparam int FSPC_BIT_PGER = 1;
	localparam int FSPC_BIT_EN = 0;
	localparam logic [4:0] FSPC_CMD_LOAD = 5'h01;
	localparam logic [4:0] FSPC_CMD_ERASE = 5'h03;
	localparam logic [4:0] FSPC_CMD_WRITE = 5'h05;
	localparam logic [4:0] FSPC_CMD_LOCK = 5'h09;
	localparam logic [4:0] FSPC_CMD_SRE = 5'h11;
	localparam logic [5:0] FSPC_CMD_SIG = 6'h21;
	localparam int FSPC_STORE_WINDOW = 4;
	localparam int FSPC_LOAD_WINDOW = 3;
	localparam logic [15:0] FSPC_SEL_FUSE_LOW = 16'h0000;
	localparam logic [15:0] FSPC_SEL_LOCK = 16'h0001;
	localparam logic [15:0] FSPC_SEL_FUSE_EXT = 16'h0002;
	localparam logic [15:0] FSPC_SEL_FUSE_HIGH = 16'h0003;
	localparam int FSPC_CLK_MHZ = 200;
	localparam int FSPC_PROG_MIN_US = 3200;
	localparam int FSPC_PROG_CYCLES = FSPC_PROG_MIN_US * FSPC_CLK_MHZ;
	localparam int FSPC_PAGE_WORDS = 32;
	typedef enum logic [1:0] {FSPC_OP_ERASE, FSPC_OP_WRITE} fspc_op_t;
endpackage

// ---- verilog/fspc_top.sv ----
// Flash self-program control register and operation sequencer
// What this block does
// RL1 - Ready interrupt requested while enable, global flag set and operation-enable clear.
// RL2 - Ready interrupt suppressed during EEPROM write or running store operation.
// RL3 - Read-while-write busy bit always reads zero.
// RL4 - Signature read: load within three cycles returns signature; store does nothing.
// RL5 - Section-read-enable command clears the whole temporary buffer.
// RL6 - Lock read: load within three cycles returns lock or fuse by pointer.
// RL7 - Page write programs buffer into page from upper pointer bits.
// RL8 - Page-write bit clears at finish or after four idle cycles.
// RL9 - Page erase erases page selected by upper pointer bits.
// RL10 - Page-erase bit clears at finish or after four idle cycles.
// RL11 - CPU stalled for the whole page write or erase.
// RL12 - Operation-enable permits store only for four cycles; other bits pick command.
// RL13 - Plain store writes register pair into buffer word; pointer bit 0 ignored.
// RL14 - Operation-enable clears after store completes or four idle cycles.
// RL15 - Operation-enable stays set until erase or write finishes.
// RL16 - Illegal command patterns in low six bits have no effect.
// RL17 - Register at data offset 0x57, I/O offset reduced by 0x20.
// RL18 - Software polls busy bit before returning to application code.
// RL19 - EEPROM write blocks the start of all programming and lock or fuse reads.
// RL20 - Lock read select: 0 fuse low, 1 lock, 2 fuse ext, 3 fuse high.
// RL21 - Buffer clears after page write, section-read-enable and reset.
// RL22 - Erase or write lasts between 3.2 ms and 3.4 ms.
// RL23 - Store with operation-enable clear changes nothing.
module fspc_top
	import fspc_pkg::*;
#(
	parameter int PROG_CYCLES = FSPC_PROG_CYCLES,
	parameter int WORD_BITS = 5,
	parameter int PAGE_BITS = 7,
	parameter logic [7:0] SIGNATURE_BYTE = 8'h5a
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_io_space,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic global_irq_flag,
	input wire logic eeprom_write_active,
	input wire logic store_req,
	input wire logic load_req,
	input wire logic [15:0] z_pointer,
	input wire logic [15:0] pair_data,
	output logic load_special,
	output logic [7:0] load_data,
	output logic cpu_stall,
	output logic program_ready_irq,
	output logic flash_erase,
	output logic flash_write,
	output logic [PAGE_BITS-1:0] page_address_field,
	output logic [15:0] flash_wdata,
	output logic [WORD_BITS-1:0] flash_word,
	input wire logic [7:0] fuse_low,
	input wire logic [7:0] fuse_high,
	input wire logic [7:0] fuse_ext,
	input wire logic [7:0] lock_bits
);
	logic [7:0] csr_r, csr_nxt;
	logic [2:0] win_r, win_nxt;
	logic busy_r, busy_nxt;
	logic [$clog2(PROG_CYCLES+1)-1:0] tmr_r, tmr_nxt;
	logic [7:0] load_data_r, load_data_nxt;
	logic load_special_r, load_special_nxt;
	logic [WORD_BITS-1:0] word_r, word_nxt;
	logic sweep_r, sweep_nxt;
	logic csr_hit, armed, cmd_legal, store_ok, load_ok;
	logic [4:0] cmd;
	logic [WORD_BITS-1:0] word_in_page_field;
	fspc_buf_if #(.AW(WORD_BITS)) buf_bus ();

	fspc_page_buf #(.AW(WORD_BITS)) u_buf (
		.clock(clock),
		.rst_n(rst_n),
		.bus(buf_bus)
	);

	function automatic logic legal_cmd(input logic [5:0] v);
		return v == {1'b0, FSPC_CMD_LOAD} || v == {1'b0, FSPC_CMD_ERASE} ||
			v == {1'b0, FSPC_CMD_WRITE} || v == {1'b0, FSPC_CMD_LOCK} ||
			v == {1'b0, FSPC_CMD_SRE} || v == FSPC_CMD_SIG;
	endfunction

	// RL17
	assign csr_hit = reg_addr == (reg_io_space ? FSPC_CSR_IO_ADDR : FSPC_CSR_DATA_ADDR);
	assign armed = csr_r[FSPC_BIT_EN] && !busy_r;
	assign cmd = csr_r[4:0];
	assign cmd_legal = legal_cmd(reg_wdata[5:0]);
	assign word_in_page_field = z_pointer[WORD_BITS:1];
	// RL12 RL19 RL23
	assign store_ok = store_req && armed && !eeprom_write_active && win_r < 3'(FSPC_STORE_WINDOW);
	assign load_ok = load_req && armed && !eeprom_write_active && win_r < 3'(FSPC_LOAD_WINDOW) &&
		(csr_r[FSPC_BIT_SIG] || csr_r[FSPC_BIT_LOCK]);

	always_comb begin
		csr_nxt = csr_r;
		win_nxt = win_r;
		busy_nxt = busy_r;
		tmr_nxt = tmr_r;
		load_data_nxt = load_data_r;
		load_special_nxt = 1'b0;
		word_nxt = word_r;
		sweep_nxt = 1'b0;
		flash_erase = 1'b0;
		flash_write = 1'b0;
		buf_bus.wr = 1'b0;
		buf_bus.clr = 1'b0;
		buf_bus.addr = word_r;
		buf_bus.wdata = pair_data;
		if (armed && csr_r[4:0] != 5'h00) begin
			win_nxt = win_r + 3'd1;
		end
		// RL8 RL10 RL14
		if (armed && win_r == 3'(FSPC_STORE_WINDOW - 1) && !store_ok) begin
			csr_nxt[5:0] = 6'h00;
		end
		if (load_ok) begin
			load_special_nxt = 1'b1;
			if (csr_r[FSPC_BIT_SIG]) begin
				load_data_nxt = SIGNATURE_BYTE; // RL4
			end else begin
				// RL6 RL20
				unique case (z_pointer[1:0])
					FSPC_SEL_FUSE_LOW[1:0]: load_data_nxt = fuse_low;
					FSPC_SEL_LOCK[1:0]: load_data_nxt = lock_bits;
					FSPC_SEL_FUSE_EXT[1:0]: load_data_nxt = fuse_ext;
					FSPC_SEL_FUSE_HIGH[1:0]: load_data_nxt = fuse_high;
				endcase
			end
			csr_nxt[5:0] = 6'h00;
		end
		if (store_ok) begin
			unique case (cmd)
				FSPC_CMD_LOAD: begin
					if (!csr_r[FSPC_BIT_SIG]) begin
						buf_bus.wr = 1'b1; // RL13
						buf_bus.addr = word_in_page_field;
					end
					csr_nxt[5:0] = 6'h00; // RL4 RL14
				end
				FSPC_CMD_ERASE: begin
					flash_erase = 1'b1; // RL9
					busy_nxt = 1'b1;
					tmr_nxt = '0;
				end
				FSPC_CMD_WRITE: begin
					busy_nxt = 1'b1; // RL7
					tmr_nxt = '0;
					word_nxt = '0;
				end
				FSPC_CMD_SRE: begin
					buf_bus.clr = 1'b1; // RL5 RL21
					csr_nxt[5:0] = 6'h00;
				end
				default: begin
					csr_nxt[5:0] = 6'h00;
				end
			endcase
		end
		if (busy_r) begin
			// RL22
			tmr_nxt = tmr_r + 1'b1;
			if (cmd[FSPC_BIT_PGWR]) begin
				flash_write = 1'b1;
				buf_bus.addr = word_r;
				word_nxt = word_r + 1'b1;
			end
			if (tmr_r == ($clog2(PROG_CYCLES+1))'(PROG_CYCLES - 1)) begin
				busy_nxt = 1'b0; // RL15
				sweep_nxt = cmd[FSPC_BIT_PGWR];
				csr_nxt[5:0] = 6'h00; // RL8 RL10
			end
		end
		if (sweep_r) begin
			buf_bus.clr = 1'b1; // RL21
		end
		if (reg_wr && csr_hit) begin
			csr_nxt[FSPC_BIT_IRQ_EN] = reg_wdata[FSPC_BIT_IRQ_EN];
			// RL16 RL19
			if (!busy_r && cmd_legal && !eeprom_write_active) begin
				csr_nxt[5:0] = reg_wdata[5:0];
				win_nxt = 3'd0;
			end
		end
		csr_nxt[FSPC_BIT_RW_BUSY] = 1'b0; // RL3
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			csr_r <= FSPC_CSR_RESET;
			win_r <= '0;
			busy_r <= 1'b0;
			tmr_r <= '0;
			load_data_r <= 8'h00;
			load_special_r <= 1'b0;
			word_r <= '0;
			sweep_r <= 1'b0;
		end else begin
			csr_r <= csr_nxt;
			win_r <= win_nxt;
			busy_r <= busy_nxt;
			tmr_r <= tmr_nxt;
			load_data_r <= load_data_nxt;
			load_special_r <= load_special_nxt;
			word_r <= word_nxt;
			sweep_r <= sweep_nxt;
		end
	end

	assign reg_rdata = (reg_rd && csr_hit) ? csr_r : 8'h00;
	assign load_data = load_data_r;
	assign load_special = load_special_r;
	assign cpu_stall = busy_r; // RL11
	// RL1 RL2
	assign program_ready_irq = csr_r[FSPC_BIT_IRQ_EN] && global_irq_flag &&
		!csr_r[FSPC_BIT_EN] && !eeprom_write_active && !busy_r;
	assign page_address_field = z_pointer[PAGE_BITS+WORD_BITS:WORD_BITS+1];
	assign flash_wdata = buf_bus.rdata;
	assign flash_word = word_r;

	property p_irq;
		@(posedge clock) disable iff (!rst_n)
		(csr_r[FSPC_BIT_IRQ_EN] && global_irq_flag && !csr_r[FSPC_BIT_EN] &&
			!eeprom_write_active) |-> program_ready_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("ready interrupt missing"); // RL1

	property p_irq_sup;
		@(posedge clock) disable iff (!rst_n)
		(busy_r || eeprom_write_active) |-> !program_ready_irq;
	endproperty
	a_irq_sup: assert property (p_irq_sup) else $error("ready interrupt not suppressed"); // RL2

	property p_busy0;
		@(posedge clock) disable iff (!rst_n)
		reg_rd |-> !reg_rdata[FSPC_BIT_RW_BUSY];
	endproperty
	a_busy0: assert property (p_busy0) else $error("busy bit not zero"); // RL3

	property p_sig_store;
		@(posedge clock) disable iff (!rst_n)
		(reg_wr && csr_hit && reg_wdata[5:0] == 6'h21 && !busy_r && !eeprom_write_active)
			##1 store_req |-> !buf_bus.wr && !flash_erase ##1 !cpu_stall;
	endproperty
	a_sig_store: assert property (p_sig_store) else $error("signature store acted"); // RL4

	property p_load_win;
		@(posedge clock) disable iff (!rst_n)
		(reg_wr && csr_hit && reg_wdata[5:0] == 6'h09 && !busy_r && !eeprom_write_active)
			##1 (load_req && !eeprom_write_active) |=> load_special;
	endproperty
	a_load_win: assert property (p_load_win) else $error("lock read not answered"); // RL6

	property p_stall;
		@(posedge clock) disable iff (!rst_n)
		(reg_wr && csr_hit && reg_wdata[5:0] inside {6'h03, 6'h05} && !busy_r &&
			!eeprom_write_active) ##1 (store_req && !eeprom_write_active)
			|=> cpu_stall && csr_r[FSPC_BIT_EN];
	endproperty
	a_stall: assert property (p_stall) else $error("no stall during operation"); // RL11

	property p_timeout;
		@(posedge clock) disable iff (!rst_n)
		(reg_wr && csr_hit && reg_wdata[5:0] inside {6'h03, 6'h05} && !busy_r &&
			!eeprom_write_active) ##1 (!store_req && !reg_wr) [*4] |=> !csr_r[FSPC_BIT_EN];
	endproperty
	a_timeout: assert property (p_timeout) else $error("enable not self cleared"); // RL8 RL10

	property p_hold;
		@(posedge clock) disable iff (!rst_n)
		busy_r |-> csr_r[FSPC_BIT_EN];
	endproperty
	a_hold: assert property (p_hold) else $error("enable dropped during operation"); // RL15

	property p_illegal;
		@(posedge clock) disable iff (!rst_n)
		(reg_wr && csr_hit && csr_r[5:0] == 6'h00 && !busy_r &&
			!(reg_wdata[5:0] inside {6'h01, 6'h03, 6'h05, 6'h09, 6'h11, 6'h21}))
			|=> csr_r[5:0] == 6'h00;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal pattern took effect"); // RL16

	property p_ee;
		@(posedge clock) disable iff (!rst_n)
		eeprom_write_active |-> !flash_erase && !buf_bus.wr;
	endproperty
	a_ee: assert property (p_ee) else $error("operation during eeprom write"); // RL19

	property p_ee_start;
		@(posedge clock) disable iff (!rst_n)
		(eeprom_write_active && !busy_r) |=> !busy_r && !load_special;
	endproperty
	a_ee_start: assert property (p_ee_start) else $error("started under eeprom write"); // RL19

	property p_noarm;
		@(posedge clock) disable iff (!rst_n)
		(store_req && !csr_r[FSPC_BIT_EN]) |-> !buf_bus.wr && !flash_erase;
	endproperty
	a_noarm: assert property (p_noarm) else $error("store acted while disarmed"); // RL23

	c_erase: cover property (@(posedge clock) disable iff (!rst_n) flash_erase);
	c_write: cover property (@(posedge clock) disable iff (!rst_n) $fell(busy_r));
	c_load: cover property (@(posedge clock) disable iff (!rst_n) load_special);
	c_clear: cover property (@(posedge clock) disable iff (!rst_n) buf_bus.clr && !sweep_r);
endmodule
